// ### design/sram_pkg.sv
package sram_pkg;
    localparam int ADDR_W = 12;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;
    localparam int DEPTH = 1 << ADDR_W;
    localparam int BURST_W = 2;
    localparam int PIPE_WR_LAT = 2;
    localparam int FLOW_WR_LAT = 1;
    localparam int SLEEP_CYC = 2;
    localparam logic [1:0] SLEEP_CNT_RST = 2'h0;
    localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
    localparam logic [LANES-1:0] LANE_RST = 4'h0;
    typedef enum logic [2:0] {
        OP_IDLE = 3'b001,
        OP_READ = 3'b010,
        OP_WRITE = 3'b100
    } burst_op_e;
endpackage : sram_pkg

// ### design/burst_counter.sv
`timescale 1ns/1ps
`default_nettype none
module burst_counter (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // control
    input wire logic load_i,
    input wire logic advance_i,
    input wire logic interleave_i,
    input wire logic [sram_pkg::BURST_W-1:0] start_i,
    // result
    output logic [sram_pkg::BURST_W-1:0] addr_o
);
    import sram_pkg::*;

    logic [BURST_W-1:0] start_r;
    logic [BURST_W-1:0] count_r;
    logic [BURST_W-1:0] step;

    // a continue uses the next count, so the first one moves off the start
    assign step = count_r + 2'h1;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            start_r <= BURST_RST;
            count_r <= BURST_RST;
        end else if (load_i) begin
            start_r <= start_i;
            count_r <= BURST_RST;
        end else if (advance_i) begin
            count_r <= step;
        end
    end

    // linear adds, interleaved xors
    always_comb begin
        if (interleave_i) begin
            addr_o = start_r ^ step;
        end else begin
            addr_o = start_r + step;
        end
    end
endmodule : burst_counter
`default_nettype wire

// ### design/sync_sram_late_write_port.sv
// Summary of operation
// - clock-gate high freezes all state except the sleep counter and sleeping_o; sleep entry still turns drivers off
// - selected, write high, load low starts read
// - any inactive select with load is deselect
// - pipeline read data via output register
// - write only lanes with enable low
// - write with no lanes is abort
// - pipeline write data two cycles after command
// - flow-through read drives without address stage
// - flow-through write data one cycle later
// - continue ignores selects and write strobe
// - continued write abort still advances counter
// - continue after deselect stays deselected
// - output enable high makes dummy read
// - drivers off during writes regardless enable
// - stall keeps read data, write stays tristated
// - outputs high impedance from power-up
// - 2-bit counter loaded, advanced on continue
// - counter wraps after four addresses
// - linear or interleaved burst order
// - flow-through select low chooses flow-through
// - sleep after two cycles, outputs tristated
`timescale 1ns/1ps
`default_nettype none
module sync_sram_late_write_port (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // command
    input wire logic clock_hold_i,
    input wire logic select_first_n_i,
    input wire logic select_second_hi_i,
    input wire logic select_third_n_i,
    input wire logic write_n_i,
    input wire logic advance_load_i,
    input wire logic [sram_pkg::LANES-1:0] lane_write_en_n_i,
    input wire logic [sram_pkg::ADDR_W-1:0] addr_i,
    // asynchronous controls, sampled
    input wire logic output_enable_n_i,
    input wire logic sleep_request_i,
    // static mode straps
    input wire logic flowthru_select_n_i,
    input wire logic burst_order_select_n_i,
    // data pins
    input wire logic [sram_pkg::DATA_W-1:0] data_i,
    output logic [sram_pkg::DATA_W-1:0] data_o,
    output logic [sram_pkg::DATA_W-1:0] data_oe_o,
    // status
    output logic sleeping_o
);
    import sram_pkg::*;

    logic [ADDR_W-1:0] rd_sel;
    logic [DATA_W-1:0] rd_word;

    logic run;
    logic sel_all;
    logic is_load;
    logic is_cont;
    logic new_read;
    logic new_write;
    logic lanes_any;
    logic flow_mode;
    burst_op_e op_r;
    burst_op_e op_nxt;
    logic [ADDR_W-1:0] base_r;
    logic [BURST_W-1:0] burst_addr;
    logic [ADDR_W-1:0] cur_addr;
    logic [ADDR_W-1:0] rd_addr_r;
    logic rd_valid_r;
    logic rd_oe_r;
    logic [ADDR_W-1:0] wa1_r;
    logic [ADDR_W-1:0] wa2_r;
    logic [LANES-1:0] wl1_r;
    logic [LANES-1:0] wl2_r;
    logic wv1_r;
    logic wv2_r;
    logic wr_now;
    logic [ADDR_W-1:0] wr_addr;
    logic [LANES-1:0] wr_lanes;
    logic [DATA_W-1:0] q_r;
    logic q_valid_r;
    logic [1:0] sleep_cnt_r;
    logic asleep;

    assign flow_mode = ~flowthru_select_n_i;
    assign asleep = sleep_cnt_r == 2'(SLEEP_CYC);
    assign run = ~clock_hold_i & ~asleep;
    assign sel_all = ~select_first_n_i & select_second_hi_i
        & ~select_third_n_i;
    assign is_load = run & ~advance_load_i;
    assign is_cont = run & advance_load_i;
    assign lanes_any = ~&lane_write_en_n_i;
    assign new_read = is_load & sel_all & write_n_i;
    assign new_write = is_load & sel_all & ~write_n_i;

    // burst type follows the load, continue keeps it
    always_comb begin
        op_nxt = op_r;
        if (is_load) begin
            if (!sel_all) begin
                op_nxt = OP_IDLE;
            end else if (write_n_i) begin
                op_nxt = OP_READ;
            end else begin
                op_nxt = OP_WRITE;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            op_r <= OP_IDLE;
            base_r <= ADDR_RST;
        end else begin
            op_r <= op_nxt;
            if (is_load && sel_all) begin
                base_r <= addr_i;
            end
        end
    end

    burst_counter u_burst (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .load_i(is_load && sel_all),
        .advance_i(is_cont && op_r != OP_IDLE),
        .interleave_i(burst_order_select_n_i),
        .start_i(addr_i[BURST_W-1:0]),
        .addr_o(burst_addr)
    );

    // address used by a continue cycle
    always_comb begin
        cur_addr = {base_r[ADDR_W-1:BURST_W], burst_addr};
    end

    // read address stage; continue after deselect stays idle
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_addr_r <= ADDR_RST;
            rd_valid_r <= 1'b0;
            rd_oe_r <= 1'b0;
        end else if (run) begin
            rd_oe_r <= ~output_enable_n_i;
            if (new_read) begin
                rd_addr_r <= addr_i;
                rd_valid_r <= 1'b1;
            end else if (is_cont && op_r == OP_READ) begin
                rd_addr_r <= cur_addr;
                rd_valid_r <= 1'b1;
            end else begin
                rd_valid_r <= 1'b0;
            end
        end
    end

    // late write pipeline, stalled by clock hold
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wa1_r <= ADDR_RST;
            wa2_r <= ADDR_RST;
            wl1_r <= LANE_RST;
            wl2_r <= LANE_RST;
            wv1_r <= 1'b0;
            wv2_r <= 1'b0;
        end else if (run) begin
            wv2_r <= wv1_r;
            wa2_r <= wa1_r;
            wl2_r <= wl1_r;
            if (new_write) begin
                wa1_r <= addr_i;
                wl1_r <= ~lane_write_en_n_i;
                wv1_r <= lanes_any;
            end else if (is_cont && op_r == OP_WRITE) begin
                wa1_r <= cur_addr;
                wl1_r <= ~lane_write_en_n_i;
                wv1_r <= lanes_any;
            end else begin
                wv1_r <= 1'b0;
            end
        end
    end

    // data taken one edge later in flow mode, two in pipeline
    always_comb begin
        if (flow_mode) begin
            wr_now = wv1_r;
            wr_addr = wa1_r;
            wr_lanes = wl1_r;
        end else begin
            wr_now = wv2_r;
            wr_addr = wa2_r;
            wr_lanes = wl2_r;
        end
    end

    // read address: flow reads at the command, pipeline one stage later
    assign rd_sel = flow_mode ? (new_read ? addr_i : cur_addr) : rd_addr_r;

    // one storage array per lane, so each lane has a single writer
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [LANE_W-1:0] lane_mem [DEPTH];
        always_ff @(posedge ref_clk_i) begin
            if (run && wr_now && wr_lanes[g]) begin
                lane_mem[wr_addr] <= data_i[g*LANE_W +: LANE_W];
            end
        end
        assign rd_word[g*LANE_W +: LANE_W] = lane_mem[rd_sel];
    end

    // output register: flow loads at address edge, pipeline one later
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q_r <= DATA_RST;
            q_valid_r <= 1'b0;
        end else if (asleep) begin
            q_valid_r <= 1'b0;
        end else if (run) begin
            if (flow_mode) begin
                q_valid_r <= new_read
                    || (is_cont && op_r == OP_READ);
                q_r <= rd_word;
            end else begin
                q_valid_r <= rd_valid_r;
                q_r <= rd_word;
            end
        end
    end

    // pin drivers registered; reset and sleep keep them off
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_o <= DATA_RST;
            data_oe_o <= DATA_RST;
        end else if (asleep) begin
            data_oe_o <= DATA_RST;
        end else if (run) begin
            if (flow_mode) begin
                data_o <= rd_word;
                data_oe_o <= {DATA_W{(new_read
                    || (is_cont && op_r == OP_READ))
                    && ~output_enable_n_i}};
            end else begin
                data_o <= rd_word;
                data_oe_o <= {DATA_W{rd_valid_r
                    && rd_oe_r}};
            end
        end else if (!q_valid_r) begin
            data_oe_o <= DATA_RST;
        end
    end

    // sleep entry after two sampled-high edges
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sleep_cnt_r <= SLEEP_CNT_RST;
            sleeping_o <= 1'b0;
        end else begin
            if (!sleep_request_i) begin
                sleep_cnt_r <= SLEEP_CNT_RST;
            end else if (sleep_cnt_r != 2'(SLEEP_CYC)) begin
                sleep_cnt_r <= sleep_cnt_r + 2'h1;
            end
            sleeping_o <= sleep_request_i
                && sleep_cnt_r >= 2'(SLEEP_CYC - 1);
        end
    end
endmodule : sync_sram_late_write_port
`default_nettype wire

// ### tb/sram_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sram_port_chk (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // command
    input wire logic clock_hold_i,
    input wire logic select_first_n_i,
    input wire logic select_second_hi_i,
    input wire logic select_third_n_i,
    input wire logic write_n_i,
    input wire logic advance_load_i,
    input wire logic output_enable_n_i,
    input wire logic sleep_request_i,
    input wire logic flowthru_select_n_i,
    // data and status
    input wire logic [sram_pkg::DATA_W-1:0] data_o,
    input wire logic [sram_pkg::DATA_W-1:0] data_oe_o,
    input wire logic sleeping_o
);
    import sram_pkg::*;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    wire logic run = !clock_hold_i && !sleep_request_i && !sleeping_o;
    wire logic sel = !select_first_n_i && select_second_hi_i
        && !select_third_n_i;
    wire logic ld = run && !advance_load_i;
    wire logic pp = flowthru_select_n_i;
    wire logic go = run && !output_enable_n_i;
    wire logic rd = ld && sel && write_n_i && !output_enable_n_i;
    wire logic ds = ld && !sel;
    chk_pipe_read: assert property (pp && rd ##1 pp && go
        |=> data_oe_o[0]) else $error("pipeline read not driven");
    chk_flow_read: assert property (!pp && rd
        |=> data_oe_o[0]) else $error("flow read not driven");
    chk_deselect_off: assert property (pp && ds ##1 pp && run
        |=> !data_oe_o[0]) else $error("deselect drove bus");
    chk_write_off: assert property (pp && ld && sel && !write_n_i
        ##1 pp && run |=> !data_oe_o[0])
        else $error("write drove bus");
    chk_dummy_read: assert property (pp && ld && sel && write_n_i
        && output_enable_n_i ##1 pp && run |=> !data_oe_o[0])
        else $error("dummy read drove bus");
    chk_cont_desel: assert property (pp && ds ##1 pp && run
        && advance_load_i ##1 pp && run |=> !data_oe_o[0])
        else $error("continue after off");
    chk_hold_freeze: assert property (clock_hold_i && !sleep_request_i
        && !sleeping_o |=> $stable(data_o) && $stable(data_oe_o))
        else $error("outputs moved during hold");
    chk_sleep_off: assert property (sleeping_o |=> data_oe_o == '0)
        else $error("bus driven while asleep");
    cover property (rd ##3 data_oe_o[0]);
    cover property (clock_hold_i && data_oe_o[0]);
    cover property (sleeping_o);
endmodule : sram_port_chk
bind sync_sram_late_write_port sram_port_chk sram_port_chk_i (.*);
`default_nettype wire

// ### tb/host_wdata.sv
`timescale 1ns/1ps
`default_nettype none
module host_wdata (
    // clock and mode
    input wire logic ref_clk_i,
    input wire logic clock_hold_i,
    input wire logic flowthru_select_n_i,
    // queued write data
    input wire logic push_i,
    input wire logic [sram_pkg::DATA_W-1:0] wdata_i,
    // data pins
    output logic [sram_pkg::DATA_W-1:0] data_o
);
    import sram_pkg::*;
    logic v1_r = 1'b0;
    logic v2_r = 1'b0;
    logic [DATA_W-1:0] d1_r, d2_r;
    logic [DATA_W-1:0] junk_r = 36'h0;
    always_ff @(posedge ref_clk_i) begin
        junk_r <= ~junk_r;
        if (!clock_hold_i) begin
            v1_r <= push_i;
            d1_r <= wdata_i;
            v2_r <= v1_r;
            d2_r <= d1_r;
        end
    end
    // late write data, one stage or two
    assign data_o = !flowthru_select_n_i ? (v1_r ? d1_r : junk_r)
        : (v2_r ? d2_r : junk_r);
endmodule : host_wdata
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sram_pkg::*;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, clock_hold_i = 1'b0;
    logic select_first_n_i = 1'b1, select_second_hi_i = 1'b0;
    logic select_third_n_i = 1'b1, write_n_i = 1'b1, advance_load_i = 1'b0;
    logic output_enable_n_i = 1'b0, sleep_request_i = 1'b0;
    logic flowthru_select_n_i = 1'b1, burst_order_select_n_i = 1'b0;
    logic [LANES-1:0] lane_write_en_n_i = 4'hf;
    logic [ADDR_W-1:0] addr_i = 12'h000, base, ea;
    logic [DATA_W-1:0] data_i, data_o, data_oe_o, wd, wdata = 36'h0;
    logic [DATA_W-1:0] mem [DEPTH];
    logic [DATA_W-1:0] exp_q [$];
    logic [31:0] rnd = 32'he67a;
    logic [1:0] cnt;
    logic sleeping_o, h_s, push = 1'b0, dummy = 1'b0;
    int kind, n_errors = 0, num_checks = 0;
    always #2.5 ref_clk_i = ~ref_clk_i;
    sync_sram_late_write_port sync_sram_late_write_port_i (.*);
    host_wdata host_wdata_i (.ref_clk_i, .clock_hold_i, .flowthru_select_n_i,
        .push_i(push), .wdata_i(wdata), .data_o(data_i));
    function logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    task chk(input logic [DATA_W-1:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task final_report;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report
    task cyc(input logic h, advance_load, wn, input logic [1:0] ds,
        input logic [3:0] ln, input logic [ADDR_W-1:0] a);
        @(posedge ref_clk_i);
        clock_hold_i <= h;
        advance_load_i <= advance_load;
        write_n_i <= wn;
        select_first_n_i <= ds == 2'h1;
        select_second_hi_i <= ds != 2'h2;
        select_third_n_i <= ds == 2'h3;
        lane_write_en_n_i <= ln;
        addr_i <= a;
        output_enable_n_i <= dummy;
        rnd = xs(rnd);
        wd = {rnd[3:0], rnd};
        wdata <= wd;
        push <= 1'b0;
        if (h) return;
        if (!advance_load) begin
            kind = ds != 0 ? 0 : wn ? 1 : 2;
            base = a;
            cnt = 2'h0;
        end else cnt++;
        ea = {base[ADDR_W-1:2], burst_order_select_n_i ? base[1:0] ^ cnt
            : base[1:0] + cnt};
        if (kind == 1 && !dummy) exp_q.push_back(mem[ea]);
        if (kind == 2 && ln != 4'hf) begin
            push <= 1'b1;
            for (int g = 0; g < LANES; g++)
                if (!ln[g]) mem[ea][9*g +: 9] = wd[9*g +: 9];
        end
    endtask : cyc
    task pass(input logic [ADDR_W-1:0] b);
        cyc(0, 0, 0, 0, 4'h0, b);
        repeat (3) cyc(0, 1, 1, 1, 4'h0, b);
        cyc(0, 0, 0, 0, 4'h5, b);
        cyc(0, 1, 0, 0, 4'hf, b);
        cyc(1, 1, 0, 0, 4'ha, b);
        cyc(0, 1, 0, 0, 4'ha, b);
        cyc(0, 0, 0, 0, 4'hf, b);
        for (int k = 1; k < 4; k++) cyc(0, 0, 1, k[1:0], 4'h0, b);
        cyc(0, 1, 1, 0, 4'h0, b);
        for (int k = 0; k < 7; k++) cyc(k == 3, k != 0, 1, 0, 4'h0, b);
        repeat (2) cyc(0, 0, 1, 1, 4'h0, b);
        dummy = 1'b1;
        cyc(0, 0, 1, 0, 4'h0, b);
        repeat (2) cyc(0, 0, 1, 1, 4'h0, b);
        dummy = 1'b0;
        repeat (3) cyc(0, 0, 1, 1, 4'h0, b);
    endtask : pass
    always @(posedge ref_clk_i) begin
        h_s = clock_hold_i;
        @(negedge ref_clk_i);
        if (!rst_i && !h_s && data_oe_o[0] === 1'b1) begin
            if (exp_q.size() > 0) chk(data_o, exp_q.pop_front());
            else chk(data_oe_o, 36'h0);
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk_i);
        chk(data_oe_o, 36'h0);
        rst_i <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            flowthru_select_n_i <= m[1];
            burst_order_select_n_i <= m[0];
            pass(rnd[ADDR_W-1:0]);
            $display("mode %0d done", m);
        end
        chk(36'(exp_q.size()), 36'h0);
        sleep_request_i <= 1'b1;
        for (int k = 0; k < 4 && sleeping_o !== 1'b1; k++)
            @(posedge ref_clk_i);
        chk(36'(sleeping_o), 36'h1);
        $display("sleep done");
        final_report();
    end
endmodule : tb
`default_nettype wire
